// ---- hw/lps_pkg.sv ----
// lps_pkg: constants, types and lane packing shared by both link ends.
// assumes: both ends see one 7:1 serialised link of four data lanes.
package lps_pkg;

    // ------------------------------------------------------------
    // link shape
    // ------------------------------------------------------------
    localparam int LANE_BITS = 7;          // bits per lane per pixel clock
    localparam int LANES = 4;
    localparam int COMP_W = 8;             // widest colour component
    localparam int LOW_W = 6;              // component bits on lanes 0..2
    localparam logic [6:0] CLK_PATTERN = 7'h63; // forwarded clock, 1100011
    localparam int BIT_DIV = 2;            // system clocks per serial bit

    // ------------------------------------------------------------
    // frame geometry
    // ------------------------------------------------------------
    localparam int H_ACTIVE = 800;
    localparam int V_ACTIVE = 600;
    localparam int H_TOTAL_TYP = 1056;
    localparam int V_TOTAL_TYP = 628;
    localparam int H_BLANK_MIN = 220;
    localparam int H_BLANK_MAX = 440;
    localparam int V_BLANK_MIN = 8;
    localparam int V_BLANK_MAX = 423;
    localparam int H_SYNC_W = 8;           // line sync width in pixel clocks
    localparam int V_SYNC_W = 2;           // frame sync width in lines
    localparam int POS_W = 11;
    localparam int FRAME_RATE_HZ = 60;
    localparam int PIX_CLK_TYP_HZ = 40000000;
    localparam int FIFO_DEPTH = 8;

    typedef logic [LANES-1:0][LANE_BITS-1:0] lps_word_t;

    typedef struct packed {
        logic pixel_valid_strobe;
        logic frame_sync;
        logic line_sync;
        logic [COMP_W-1:0] red;
        logic [COMP_W-1:0] green;
        logic [COMP_W-1:0] blue;
    } lps_pixel_t;

    // lane 3 stays low in 6-bit mode, as if unconnected
    function automatic lps_word_t lps_pack(input lps_pixel_t p, input logic depth8);
        lps_word_t w;
        w[0] = {p.green[0], p.red[5:0]};
        w[1] = {p.blue[1:0], p.green[5:1]};
        w[2] = {p.pixel_valid_strobe, p.frame_sync, p.line_sync, p.blue[5:2]};
        w[3] = depth8 ? {1'b0, p.blue[7:6], p.green[7:6], p.red[7:6]} : 7'h00;
        return w;
    endfunction : lps_pack

    // 6-bit mode leaves bits 7:6 zero, value in 5:0 with bit 5 as msb
    function automatic lps_pixel_t lps_unpack(input lps_word_t w, input logic depth8);
        lps_pixel_t p;
        logic [1:0] hr;
        logic [1:0] hg;
        logic [1:0] hb;
        hr = depth8 ? w[3][1:0] : 2'h0;
        hg = depth8 ? w[3][3:2] : 2'h0;
        hb = depth8 ? w[3][5:4] : 2'h0;
        p.red = {hr, w[0][5:0]};
        p.green = {hg, w[1][4:0], w[0][6]};
        p.blue = {hb, w[2][3:0], w[1][6:5]};
        p.line_sync = w[2][4];
        p.frame_sync = w[2][5];
        p.pixel_valid_strobe = w[2][6];
        return p;
    endfunction : lps_unpack

endpackage : lps_pkg

// ---- hw/lps_link_if.sv ----
// lps_link_if: the panel link wires between host transmitter and panel.
// assumes: the host drives every wire; the panel only listens.
`timescale 1ns/100ps
`default_nettype none
interface lps_link_if;
    logic bit_clock;           // serial bit clock, made by the host from i_clk
    logic link_clock_pair;     // forwarded pixel clock, 1100011 per word
    logic lane_zero;
    logic lane_one;
    logic lane_two;
    logic lane_three;
    logic colour_depth_select;
    logic reverse_scan_select;
    logic test_out;            // factory test pin, host side
    logic test_oe_n;           // low while the host drives it

    modport host (output bit_clock, link_clock_pair, lane_zero, lane_one, lane_two,
        lane_three, colour_depth_select, reverse_scan_select, test_out, test_oe_n);
    modport device (input bit_clock, link_clock_pair, lane_zero, lane_one, lane_two,
        lane_three, colour_depth_select, reverse_scan_select);
endinterface : lps_link_if
`default_nettype wire

// ---- hw/lps_fifo.sv ----
// lps_fifo: synchronous pixel FIFO, valid/ready on both sides.
// assumes: one clock; DEPTH a power of two.
`timescale 1ns/100ps
`default_nettype none
module lps_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_in_valid,
    output logic o_in_ready,
    input wire logic [WIDTH-1:0] i_in_data,
    output logic o_out_valid,
    input wire logic i_out_ready,
    output logic [WIDTH-1:0] o_out_data
);
    localparam int AW = $clog2(DEPTH);

    if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
        $error("lps_fifo: DEPTH must be a power of two, at least 2");
    end

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
    logic [AW:0] next_count;
    logic push;
    logic pop;

    // full and empty are registered so o_in_ready and o_out_valid come from flops
    assign push = i_in_valid && o_in_ready;
    assign pop = i_out_ready && o_out_valid;
    assign next_count = count + (AW+1)'(push) - (AW+1)'(pop);
    assign o_out_data = mem[rd_ptr];

    // storage has no reset; only words counted in are ever read
    always_ff @(posedge i_clk) begin
        if (push) begin
            mem[wr_ptr] <= i_in_data;
        end
    end

    // pointers wrap naturally at a power-of-two depth
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
            o_in_ready <= 1'b0;
            o_out_valid <= 1'b0;
        end else begin
            wr_ptr <= wr_ptr + AW'(push);
            rd_ptr <= rd_ptr + AW'(pop);
            count <= next_count;
            o_in_ready <= (next_count != (AW+1)'(DEPTH));
            o_out_valid <= (next_count != '0);
        end
    end
endmodule : lps_fifo
`default_nettype wire

// ---- hw/lps_panel_rx.sv ----
// lps_panel_rx: panel end; deserialises the link and delivers pixels.
// assumes: link wires change on bit_clock falling edges; i_clk well
// above the pixel rate so one word crosses before the next arrives.
`timescale 1ns/100ps
`default_nettype none
module lps_panel_rx
    import lps_pkg::*;
(
    lps_link_if.device link,
    input wire logic i_clk,
    input wire logic i_rst_n,
    output logic o_pix_valid,
    output logic [COMP_W-1:0] o_red,
    output logic [COMP_W-1:0] o_green,
    output logic [COMP_W-1:0] o_blue,
    output logic [POS_W-1:0] o_x,
    output logic [POS_W-1:0] o_y,
    output logic o_line_sync,
    output logic o_frame_sync,
    output logic o_depth8
);
    // ------------------------------------------------------------
    // link domain
    // ------------------------------------------------------------
    logic rst_meta;
    logic link_rst_n;
    logic [LANES:0][LANE_BITS-1:0] sh;
    logic [LANES:0][LANE_BITS-1:0] next_sh;
    lps_word_t cap;
    logic cap_tog;

    // reset carried into the link domain by two flops
    always_ff @(posedge link.bit_clock) begin
        rst_meta <= i_rst_n;
        link_rst_n <= rst_meta;
    end

    // each lane shifts one bit per bit clock, oldest bit in the msb
    always_comb begin
        next_sh[0] = {sh[0][5:0], link.lane_zero};
        next_sh[1] = {sh[1][5:0], link.lane_one};
        next_sh[2] = {sh[2][5:0], link.lane_two};
        next_sh[3] = {sh[3][5:0], link.lane_three};
        next_sh[4] = {sh[4][5:0], link.link_clock_pair};
    end

    // no reset on the shifter: it keeps sampling while the link reset
    // drains, so the first word after power-up still forms whole
    always_ff @(posedge link.bit_clock) begin
        sh <= next_sh;
    end

    // a full word stands once the clock lane shows its pattern; the
    // capture lands on the word's last bit, after the forwarded clock has risen
    always_ff @(posedge link.bit_clock) begin
        if (!link_rst_n) begin
            cap <= '0;
            cap_tog <= 1'b0;
        end else if (next_sh[LANES] == CLK_PATTERN) begin
            cap <= next_sh[LANES-1:0];
            cap_tog <= ~cap_tog;
        end
    end

    // ------------------------------------------------------------
    // system domain
    // ------------------------------------------------------------
    logic [2:0] tog_s;
    logic [1:0] depth_s;
    logic [1:0] rev_s;
    logic word_evt;
    lps_pixel_t px;
    logic de_prev;
    logic vs_prev;
    logic [POS_W-1:0] x_cnt;
    logic [POS_W-1:0] y_cnt;

    // toggle handshake; cap holds for a whole word, so it is safe to read
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            tog_s <= '0;
            depth_s <= '0;
            rev_s <= '0;
        end else begin
            tog_s <= {tog_s[1:0], cap_tog};
            depth_s <= {depth_s[0], link.colour_depth_select};
            rev_s <= {rev_s[0], link.reverse_scan_select};
        end
    end

    assign word_evt = tog_s[2] ^ tog_s[1];
    assign px = lps_unpack(cap, depth_s[1]);

    // only words under a high strobe reach the pixel outputs
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            o_pix_valid <= 1'b0;
            o_red <= '0;
            o_green <= '0;
            o_blue <= '0;
            o_line_sync <= 1'b0;
            o_frame_sync <= 1'b0;
            o_depth8 <= 1'b0;
        end else begin
            o_pix_valid <= word_evt && px.pixel_valid_strobe;
            o_depth8 <= depth_s[1];
            if (word_evt) begin
                o_line_sync <= px.line_sync;
                o_frame_sync <= px.frame_sync;
            end
            if (word_evt && px.pixel_valid_strobe) begin
                o_red <= px.red;
                o_green <= px.green;
                o_blue <= px.blue;
            end
        end
    end

    // position tracking: strobe fall ends a line, frame sync rise a frame
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            x_cnt <= '0;
            y_cnt <= '0;
            de_prev <= 1'b0;
            vs_prev <= 1'b0;
            o_x <= '0;
            o_y <= '0;
        end else if (word_evt) begin
            de_prev <= px.pixel_valid_strobe;
            vs_prev <= px.frame_sync;
            if (px.pixel_valid_strobe) begin
                x_cnt <= x_cnt + POS_W'(1);
                o_x <= rev_s[1] ? POS_W'(H_ACTIVE - 1) - x_cnt : x_cnt;
                o_y <= rev_s[1] ? POS_W'(V_ACTIVE - 1) - y_cnt : y_cnt;
            end else begin
                x_cnt <= '0;
            end
            if (px.frame_sync && !vs_prev) begin
                y_cnt <= '0;
            end else if (!px.pixel_valid_strobe && de_prev) begin
                y_cnt <= y_cnt + POS_W'(1);
            end
        end
    end
endmodule : lps_panel_rx
`default_nettype wire

// ---- hw/lps_host_tx.sv ----
// lps_host_tx: host end; frames pixels and serialises them onto the link.
// assumes: pixels arrive in raster order over valid/ready; the link's
// bit clock is made here by dividing i_clk.
//
// Contract
// - depth select high means 8-bit colour
// - lane zero: red 0-5, green 0
// - lane one: green 1-5, blue 0-1
// - lane two: blue 2-5, syncs, strobe
// - lane three: colour msbs; idle in 6-bit
// - reverse select high scans image backwards
// - host forwards the pixel clock
// - data valid wherever the strobe is high
// - panel samples strobe on clock fall; lps_panel_rx takes the word on its last bit, clock high
// - 8-bit: bit 7 msb, bit 0 lsb
// - 6-bit: bit 5 msb, bit 0 lsb
// - all pins low while panel unpowered
// - frames repeat at sixty hertz
// - factory test pin never driven
`timescale 1ns/100ps
`default_nettype none
module lps_host_tx
    import lps_pkg::*;
#(
    parameter int H_TOTAL = H_TOTAL_TYP,
    parameter int V_TOTAL = V_TOTAL_TYP,
    parameter int DEPTH = FIFO_DEPTH
) (
    lps_link_if.host link,
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_panel_power,
    input wire logic i_depth8,
    input wire logic i_reverse,
    input wire logic i_pix_valid,
    output logic o_pix_ready,
    input wire logic [COMP_W-1:0] i_red,
    input wire logic [COMP_W-1:0] i_green,
    input wire logic [COMP_W-1:0] i_blue,
    output logic o_underrun,
    output logic o_frame_start
);
    // ------------------------------------------------------------
    // parameter checks
    // ------------------------------------------------------------
    // the blanking the panel accepts bounds both totals
    if (H_TOTAL - H_ACTIVE < H_BLANK_MIN || H_TOTAL - H_ACTIVE > H_BLANK_MAX) begin : g_bad_h
        $error("lps_host_tx: H_TOTAL gives blanking outside the panel range");
    end
    if (V_TOTAL - V_ACTIVE < V_BLANK_MIN || V_TOTAL - V_ACTIVE > V_BLANK_MAX) begin : g_bad_v
        $error("lps_host_tx: V_TOTAL gives blanking outside the panel range");
    end
    if (BIT_DIV != 2) begin : g_bad_div
        $error("lps_host_tx: the bit clock divider only serves a ratio of two");
    end

    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_OFF = 2'b01,
        ST_RUN = 2'b10
    } lps_tx_state_t;

    localparam int FIFO_W = 3 * COMP_W;
    localparam logic [2:0] LAST_BIT = 3'(LANE_BITS - 1);

    lps_tx_state_t state;
    logic bit_tog;
    logic [2:0] bit_idx;
    logic [POS_W-1:0] h_cnt;
    logic [POS_W-1:0] v_cnt;
    logic [LANES:0][LANE_BITS-1:0] sh;
    logic [LANES:0][LANE_BITS-1:0] src;
    logic depth_frame;
    logic step;
    logic word_end;
    logic active;
    logic fifo_valid;
    logic [FIFO_W-1:0] fifo_data;
    lps_pixel_t pix;

    // ------------------------------------------------------------
    // pixel buffer
    // ------------------------------------------------------------
    // the source stalls on o_pix_ready; the link never waits, so a
    // buffer that runs dry during active video sends black instead
    lps_fifo #(
        .WIDTH(FIFO_W),
        .DEPTH(DEPTH)
    ) u_fifo (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .i_in_valid(i_pix_valid),
        .o_in_ready(o_pix_ready),
        .i_in_data({i_red, i_green, i_blue}),
        .o_out_valid(fifo_valid),
        .i_out_ready(word_end && active),
        .o_out_data(fifo_data)
    );

    // ------------------------------------------------------------
    // word timing
    // ------------------------------------------------------------
    // a serial bit lasts two system clocks; lanes move when bit_tog is high
    assign step = (state == ST_RUN) && bit_tog;
    assign word_end = step && (bit_idx == LAST_BIT);
    assign active = (h_cnt < POS_W'(H_ACTIVE)) && (v_cnt < POS_W'(V_ACTIVE));

    // build the next pixel word; sync pulses sit at the start of blanking
    always_comb begin
        pix.pixel_valid_strobe = active;
        pix.line_sync = (h_cnt >= POS_W'(H_ACTIVE)) && (h_cnt < POS_W'(H_ACTIVE + H_SYNC_W));
        pix.frame_sync = (v_cnt >= POS_W'(V_ACTIVE)) && (v_cnt < POS_W'(V_ACTIVE + V_SYNC_W));
        pix.red = '0;
        pix.green = '0;
        pix.blue = '0;
        if (active && fifo_valid) begin
            {pix.red, pix.green, pix.blue} = fifo_data;
        end
    end

    // at a word boundary the fresh word replaces the shift contents
    always_comb begin
        if (bit_idx == LAST_BIT) begin
            src = {CLK_PATTERN, lps_pack(pix, depth_frame)};
        end else begin
            src = sh;
        end
    end

    // power gating: running only while the panel supply is up
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            state <= ST_OFF;
        end else begin
            unique case (state)
                ST_OFF: begin
                    if (i_panel_power) begin
                        state <= ST_RUN;
                    end
                end
                ST_RUN: begin
                    if (!i_panel_power) begin
                        state <= ST_OFF;
                    end
                end
            endcase
        end
    end

    // bit phase and bit index; a new run always starts on a word edge
    always_ff @(posedge i_clk) begin
        if (!i_rst_n || state != ST_RUN) begin
            bit_tog <= 1'b0;
            bit_idx <= LAST_BIT;
        end else begin
            bit_tog <= ~bit_tog;
            if (step) begin
                bit_idx <= (bit_idx == LAST_BIT) ? 3'h0 : bit_idx + 3'h1;
            end
        end
    end

    // raster counters; one count per word, i.e. per pixel clock
    always_ff @(posedge i_clk) begin
        if (!i_rst_n || state != ST_RUN) begin
            h_cnt <= '0;
            v_cnt <= '0;
        end else if (word_end) begin
            if (h_cnt == POS_W'(H_TOTAL - 1)) begin
                h_cnt <= '0;
                v_cnt <= (v_cnt == POS_W'(V_TOTAL - 1)) ? '0 : v_cnt + POS_W'(1);
            end else begin
                h_cnt <= h_cnt + POS_W'(1);
            end
        end
    end

    // lane packing depth is taken once per frame so a frame's lane words never mix formats; the depth strap follows i_depth8 directly
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            depth_frame <= 1'b0;
        end else if (state != ST_RUN || (h_cnt == '0 && v_cnt == '0)) begin
            depth_frame <= i_depth8;
        end
    end

    // shift register: msb goes out first on each lane
    always_ff @(posedge i_clk) begin
        if (!i_rst_n || state != ST_RUN) begin
            sh <= '0;
        end else if (step) begin
            for (int l = 0; l <= LANES; l++) begin
                sh[l] <= {src[l][5:0], 1'b0};
            end
        end
    end

    // ------------------------------------------------------------
    // link pins
    // ------------------------------------------------------------
    // lanes change as bit_clock falls, the panel samples as it rises;
    // everything is held low while the panel supply is off
    always_ff @(posedge i_clk) begin
        if (!i_rst_n || state != ST_RUN) begin
            link.bit_clock <= 1'b0;
            link.link_clock_pair <= 1'b0;
            link.lane_zero <= 1'b0;
            link.lane_one <= 1'b0;
            link.lane_two <= 1'b0;
            link.lane_three <= 1'b0;
        end else begin
            link.bit_clock <= ~bit_tog;
            if (step) begin
                link.link_clock_pair <= src[LANES][6];
                link.lane_zero <= src[0][6];
                link.lane_one <= src[1][6];
                link.lane_two <= src[2][6];
                link.lane_three <= src[3][6];
            end
        end
    end

    // mode straps follow the user, but only while the panel is powered
    always_ff @(posedge i_clk) begin
        if (!i_rst_n || !i_panel_power) begin
            link.colour_depth_select <= 1'b0;
            link.reverse_scan_select <= 1'b0;
        end else begin
            link.colour_depth_select <= i_depth8;
            link.reverse_scan_select <= i_reverse;
        end
    end

    // the factory test pin is released for good
    always_ff @(posedge i_clk) begin
        link.test_out <= 1'b0;
        link.test_oe_n <= 1'b1;
    end

    // ------------------------------------------------------------
    // status pulses
    // ------------------------------------------------------------
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            o_underrun <= 1'b0;
            o_frame_start <= 1'b0;
        end else begin
            o_underrun <= word_end && active && !fifo_valid;
            o_frame_start <= word_end && (h_cnt == '0) && (v_cnt == '0);
        end
    end
endmodule : lps_host_tx
`default_nettype wire

// ---- testbench/lps_link_properties.sv ----
// lps_link_properties: timing checks on the panel link wires.
// assumes: wires are registered on the host's i_clk.
`timescale 1ns/100ps
`default_nettype none
module lps_link_checker (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_panel_power,
    input wire logic bit_clock,
    input wire logic link_clock_pair,
    input wire logic lane_zero,
    input wire logic lane_one,
    input wire logic lane_two,
    input wire logic lane_three,
    input wire logic colour_depth_select,
    input wire logic reverse_scan_select,
    input wire logic test_out,
    input wire logic test_oe_n
);
    // ----
    // link properties
    // ----
    // a power drop restarts the serialiser, so running checks pause then
    wire logic run = i_rst_n && i_panel_power;
    wire logic any_pin = bit_clock | link_clock_pair | lane_zero | lane_one | lane_two | lane_three
        | colour_depth_select | reverse_scan_select;
    wire logic [3:0] lanes = {lane_three, lane_two, lane_one, lane_zero};

    property p_test_idle; @(posedge i_clk) disable iff (!i_rst_n) test_oe_n && !test_out; endproperty
    a_test_idle: assert property (p_test_idle) else $error("test pin driven");
    property p_power_off; @(posedge i_clk) disable iff (!i_rst_n) !i_panel_power [*3] |-> !any_pin; endproperty
    a_power_off: assert property (p_power_off) else $error("pin high while unpowered");
    property p_lane3_idle; @(posedge i_clk) disable iff (!run) !colour_depth_select |-> !lane_three; endproperty
    a_lane3_idle: assert property (p_lane3_idle) else $error("lane three busy in 6-bit");
    property p_lane3_rsvd; @(posedge i_clk) disable iff (!run) $fell(bit_clock) && link_clock_pair
        && $past(link_clock_pair, 4) && !$past(link_clock_pair, 6) |-> !lane_three; endproperty
    a_lane3_rsvd: assert property (p_lane3_rsvd) else $error("reserved bit set");
    property p_lane_move; @(posedge i_clk) disable iff (!run) $changed(lanes) |-> $fell(bit_clock); endproperty
    a_lane_move: assert property (p_lane_move) else $error("lane moved off bit edge");
    property p_bit_hold; @(posedge i_clk) disable iff (!run) $fell(bit_clock) |=> bit_clock ##1 !bit_clock; endproperty
    a_bit_hold: assert property (p_bit_hold) else $error("bit clock stalled");
    property p_clk_frame; @(posedge i_clk) disable iff (!run) $fell(link_clock_pair)
        |-> !link_clock_pair [*6] ##1 link_clock_pair [*8] ##1 !link_clock_pair; endproperty
    a_clk_frame: assert property (p_clk_frame) else $error("clock lane pattern wrong");
    property p_lane_stay; @(posedge i_clk) disable iff (!run) $rose(bit_clock) |-> $stable(lanes); endproperty
    a_lane_stay: assert property (p_lane_stay) else $error("lane moved at sampling edge");
endmodule : lps_link_checker
`default_nettype wire

// ---- testbench/lvds_panel_pixel_input_tb.sv ----
// lvds_panel_pixel_input_tb: host and panel back to back, fed a ramp.
// assumes: shortened totals; each run covers the first line and the start of the second.
`timescale 1ns/100ps
`default_nettype none
module lvds_panel_pixel_input_tb;
    import lps_pkg::*;
    logic i_clk = 1'b0;
    logic i_rst_n = 1'b0;
    logic rx_rst_n = 1'b0;
    logic pwr = 1'b0;
    logic depth8 = 1'b0;
    logic rev = 1'b0;
    logic pv = 1'b0;
    logic [23:0] px = 24'h0;
    logic pr, under, vld, dep, ls, fs, fst;
    logic [7:0] r, g, b;
    logic [POS_W-1:0] x, y;
    int failures = 0;
    int samples_checked = 0;
    int fed, n_feed, k, row0, unders, lines, vlds, starts;

    lps_link_if lps_link_if_i ();
    lps_host_tx #(.H_TOTAL(1020), .V_TOTAL(608)) lps_host_tx_i (.link(lps_link_if_i), .i_clk(i_clk),
        .i_rst_n(i_rst_n), .i_panel_power(pwr), .i_depth8(depth8), .i_reverse(rev), .i_pix_valid(pv),
        .o_pix_ready(pr), .i_red(px[23:16]), .i_green(px[15:8]), .i_blue(px[7:0]), .o_underrun(under),
        .o_frame_start(fst));
    lps_panel_rx lps_panel_rx_i (.link(lps_link_if_i), .i_clk(i_clk), .i_rst_n(rx_rst_n), .o_pix_valid(vld),
        .o_red(r), .o_green(g), .o_blue(b), .o_x(x), .o_y(y), .o_line_sync(ls), .o_frame_sync(fs), .o_depth8(dep));
    lps_link_checker lps_link_checker_i (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_panel_power(pwr),
        .bit_clock(lps_link_if_i.bit_clock), .link_clock_pair(lps_link_if_i.link_clock_pair),
        .lane_zero(lps_link_if_i.lane_zero), .lane_one(lps_link_if_i.lane_one), .lane_two(lps_link_if_i.lane_two),
        .lane_three(lps_link_if_i.lane_three), .colour_depth_select(lps_link_if_i.colour_depth_select),
        .reverse_scan_select(lps_link_if_i.reverse_scan_select), .test_out(lps_link_if_i.test_out),
        .test_oe_n(lps_link_if_i.test_oe_n));

    // ----
    // helpers
    // ----
    // ramp value of pixel k; 6-bit mode only carries the low six bits
    function automatic logic [23:0] pat(input int i, input logic full);
        logic [23:0] v;
        v = {i[7:0], i[9:2] ^ 8'hC3, i[8:1] + 8'h3C};
        return full ? v : v & 24'h3F3F3F;
    endfunction : pat

    task automatic check(input string what, input logic [23:0] exp, input logic [23:0] got);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("unexpected %s: expected %0h, seen %0h", what, exp, got);
        end
    endtask : check

    task automatic stop_test();
        if (failures == 0 && samples_checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : stop_test

    always #5 i_clk = ~i_clk;

    // feeder holds a refused pixel until the fifo takes it
    always @(posedge i_clk) begin
        if (!i_rst_n) fed = 0;
        else if (pv && pr) fed++;
        #1;
        pv = i_rst_n && fed < n_feed;
        px = pat(fed, 1'b1);
    end

    // monitor traces each shown pixel back to its ramp index by position
    always @(posedge i_clk) begin
        if (under === 1'b1) unders++;
        if (fst === 1'b1) starts++;
        if ($rose(ls)) lines++;
        if (vld === 1'b1) begin
            vlds++;
            k = rev ? (599 - int'(y)) * 800 + 799 - int'(x) : int'(y) * 800 + int'(x);
            if (k < 800) row0++;
            check("pixel", k < n_feed ? pat(k, depth8) : 24'h0, {r, g, b});
        end
    end

    // ----
    // scenarios
    // ----
    // power stays off until the fifo is full, so no startup underrun
    task automatic run(input logic d8, input logic rv, input int n);
        i_rst_n = 1'b0;
        rx_rst_n = 1'b0;
        pwr = 1'b0;
        depth8 = d8;
        rev = rv;
        n_feed = n;
        starts = 0;
        repeat (2) @(posedge i_clk);
        #1 i_rst_n = 1'b1;
        repeat (12) @(posedge i_clk);
        #1 pwr = 1'b1;
        repeat (8) @(posedge i_clk);
        #1 rx_rst_n = 1'b1;
        row0 = 0;
        unders = 0;
        lines = 0;
        repeat (15000) @(posedge i_clk);
        #1;
        check("depth", {23'h0, d8}, {23'h0, dep});
        check("row count", 24'h1, {23'h0, row0 == 800});
        check("line syncs", 24'h1, {23'h0, lines == 1});
        check("frame sync", 24'h0, {23'h0, fs});
        check("frame starts", 24'h1, starts[23:0]);
        check("underruns", 24'h1, {23'h0, n < 800 ? unders >= 800 - n : unders == 0});
    endtask : run

    task automatic power_off();
        pwr = 1'b0;
        repeat (20) @(posedge i_clk);
        #1 vlds = 0;
        repeat (30) @(posedge i_clk);
        #1;
        check("pixels while unpowered", 24'h0, vlds[23:0]);
    endtask : power_off

    initial begin
        #1;
        run(1'b0, 1'b0, 900);
        run(1'b1, 1'b0, 900);
        run(1'b1, 1'b1, 400);
        power_off();
        stop_test();
    end

    // watchdog well past the three runs
    initial begin
        #800000;
        failures++;
        stop_test();
    end
endmodule : lvds_panel_pixel_input_tb
`default_nettype wire
